// *** src/lit_ops_pkg.sv ***
// Package with encodings, field positions and reset values for the literal and power-down ops
package lit_ops_pkg;
    localparam int         INSN_W         = 14;
    localparam int         DATA_W         = 8;
    localparam int         WD_W           = 8;
    localparam int         PS_W           = 8;
    localparam int         LIT_LSB        = 0;
    localparam int         OPC_LSB        = 8;
    localparam int         OPC_W          = 6;
    localparam int         DC_BIT         = 3;
    // Full power-down instruction word
    localparam logic [13:0] PWRDN_WORD    = 14'h0063;
    // Upper six bits: 11 110x and 11 1010
    localparam logic [4:0] SUB_OPC_HI     = 5'h1e;
    localparam logic [5:0] XOR_OPC        = 6'h3a;
    localparam logic [7:0] ACC_RST        = 8'h00;
    localparam logic [7:0] WD_CLEAR       = 8'h00;
    localparam logic [7:0] PS_CLEAR       = 8'h00;

    // Status flags carried together
    typedef struct packed {
        logic timeout_n;
        logic powerdown_n;
        logic zero;
        logic digit_carry;
        logic carry;
    } status_t;

    localparam status_t STATUS_RST = '{timeout_n: 1'b1, powerdown_n: 1'b1, zero: 1'b0,
                                       digit_carry: 1'b0, carry: 1'b0};

    // Whole block state
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] watchdog;
        logic [7:0] prescale;
        status_t    status;
        logic       osc_run;
        logic       sleeping;
    } core_state_t;
endpackage : lit_ops_pkg

// *** src/lit_ops_core.sv ***
// Decode and execute of power-down, literal-minus-accumulator and xor-literal instructions
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Power-down word stops oscillator, enters sleep
// - Power-down clears watchdog, prescaler, sets status
// - 11 110x computes literal minus accumulator
// - 11 1010 decodes as xor literal
// - Xor result to accumulator, only zero
module lit_ops_core
    import lit_ops_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              exec_valid_in,
    input  wire logic [13:0]       insn_in,
    input  wire logic              wake_in,
    input  wire logic              watchdog_tick_in,
    output logic      [7:0]        acc_out,
    output logic      [7:0]        watchdog_out,
    output logic      [7:0]        prescale_out,
    output status_t                status_out,
    output logic                   osc_run_out,
    output logic                   sleep_out
);

    core_state_t state_reg;
    core_state_t state_next;

    logic        insn_taken;
    logic        is_pwrdn;
    logic        is_sub;
    logic        is_xor;
    logic [8:0]  sub_full;
    logic [4:0]  sub_low;
    logic [7:0]  lit;
    logic [7:0]  xor_res;
    logic [15:0] wd_chain;

    // Values held during and just after reset
    localparam core_state_t CORE_RST = '{
        acc:      ACC_RST,
        watchdog: WD_CLEAR,
        prescale: PS_CLEAR,
        status:   STATUS_RST,
        osc_run:  1'b1,
        sleeping: 1'b0
    };

    // Instruction fields and decode
    always_comb begin
        lit        = insn_in[LIT_LSB +: DATA_W];
        insn_taken = exec_valid_in && !state_reg.sleeping;
        is_pwrdn   = insn_taken && (insn_in == PWRDN_WORD);
        // bit 8 is a don't care
        is_sub     = insn_taken && (insn_in[13:9] == SUB_OPC_HI);
        is_xor     = insn_taken && (insn_in[OPC_LSB +: OPC_W] == XOR_OPC);
    end

    // Two's complement subtract, xor and watchdog chain
    always_comb begin
        // k + ~W + 1, bit 8 is the not-borrow carry
        sub_full = {1'b0, lit} + {1'b0, ~state_reg.acc} + 9'h001;
        sub_low  = {1'b0, lit[3:0]} + {1'b0, ~state_reg.acc[3:0]} + 5'h01;
        xor_res  = state_reg.acc ^ lit;
        // Watchdog chain, prescaler in the low byte
        wd_chain = 16'({state_reg.watchdog, state_reg.prescale} + 16'h0001);
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        if (is_pwrdn) begin
            state_next.watchdog           = WD_CLEAR;
            state_next.prescale           = PS_CLEAR;
            state_next.status.timeout_n   = 1'b1;
            state_next.status.powerdown_n = 1'b0;
            state_next.osc_run            = 1'b0;
            state_next.sleeping           = 1'b1;
        end else if (is_sub) begin
            state_next.acc                = sub_full[7:0];
            state_next.status.carry       = sub_full[8];
            state_next.status.digit_carry = sub_low[4];
            state_next.status.zero        = (sub_full[7:0] == 8'h00);
        end else if (is_xor) begin
            state_next.acc                = xor_res;
            state_next.status.zero        = (xor_res == 8'h00);
        end else if (state_reg.sleeping && wake_in) begin
            // Wake reverses sleep, status kept
            state_next.osc_run            = 1'b1;
            state_next.sleeping           = 1'b0;
        end else if (!state_reg.sleeping && watchdog_tick_in) begin
            // Plain watchdog advance while running
            {state_next.watchdog, state_next.prescale} = wd_chain;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= CORE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Datapath and watchdog outputs
    assign acc_out      = state_reg.acc;
    assign watchdog_out = state_reg.watchdog;
    assign prescale_out = state_reg.prescale;

    // Status and power outputs
    assign status_out   = state_reg.status;
    assign osc_run_out  = state_reg.osc_run;
    assign sleep_out    = state_reg.sleeping;

    // Checks on the registered outputs
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    pwrdn_stop_a: assert property (is_pwrdn |=> !osc_run_out && sleep_out)
        else $error("power-down did not stop oscillator");
    osc_pair_a: assert property (osc_run_out == !sleep_out)
        else $error("oscillator and sleep disagree");
    sleep_hold_a: assert property (
        sleep_out && !wake_in |=> sleep_out && $stable(acc_out) && $stable(status_out)
        && $stable(watchdog_out) && $stable(prescale_out))
        else $error("state moved while asleep");
    wake_resume_a: assert property (
        sleep_out && wake_in |=> !sleep_out && osc_run_out && $stable(status_out))
        else $error("wake did not restart the oscillator");

    pwrdn_stat_a: assert property (
        is_pwrdn |=> watchdog_out == WD_CLEAR && prescale_out == PS_CLEAR
        && status_out.timeout_n && !status_out.powerdown_n
        && status_out.carry == $past(status_out.carry))
        else $error("power-down status wrong");
    pwrdn_keep_a: assert property (
        is_pwrdn |=> $stable(acc_out) && status_out.zero == $past(status_out.zero)
        && status_out.digit_carry == $past(status_out.digit_carry))
        else $error("power-down touched other state");
    // watchdog chain advances on a tick
    tick_adv_a: assert property (
        watchdog_tick_in && !sleep_out && !exec_valid_in
        |=> {watchdog_out, prescale_out}
            == 16'($past({watchdog_out, prescale_out}) + 16'h0001))
        else $error("watchdog chain did not advance");

    sub_result_a: assert property (
        is_sub |=> acc_out == 8'($past(lit) - $past(acc_out)))
        else $error("subtract result wrong");
    sub_zero_a: assert property (is_sub |=> status_out.zero == (acc_out == 8'h00))
        else $error("subtract zero flag wrong");
    sub_dc_a: assert property (
        is_sub |=> status_out.digit_carry == ($past(lit[3:0]) >= $past(acc_out[3:0])))
        else $error("subtract digit carry wrong");
    sub_tick_a: assert property (
        is_sub |=> $stable(watchdog_out) && $stable(prescale_out) && !sleep_out)
        else $error("subtract disturbed the watchdog");

    decode_excl_a: assert property ($onehot0({is_pwrdn, is_sub, is_xor}))
        else $error("instruction decodes overlap");
    xor_decode_a: assert property (
        is_xor |=> acc_out == ($past(acc_out) ^ $past(lit)))
        else $error("xor result wrong");
    word_ignore_a: assert property (
        exec_valid_in && !sleep_out && !is_pwrdn && !is_sub && !is_xor
        && !watchdog_tick_in
        |=> $stable(acc_out) && $stable(status_out)
        && $stable(watchdog_out) && $stable(prescale_out) && !sleep_out)
        else $error("undecoded word changed state");

    xor_flags_a: assert property (
        is_xor |=> status_out.carry == $past(status_out.carry)
        && status_out.digit_carry == $past(status_out.digit_carry)
        && status_out.zero == (acc_out == 8'h00))
        else $error("xor flags wrong");
    // xor blocks a tick, stays awake
    xor_keep_a: assert property (
        is_xor |=> $stable(watchdog_out) && $stable(prescale_out) && !sleep_out)
        else $error("xor disturbed the watchdog");

    sub_carry_a: assert property (
        is_sub |=> status_out.carry == ($past(lit) >= $past(acc_out)))
        else $error("subtract carry wrong");

    // Main scenarios reached
    cov_pwrdn_c: cover property (is_pwrdn ##1 sleep_out ##[1:20] !sleep_out);
    cov_borrow_c: cover property (is_sub && !sub_full[8]);
    cov_sub_zero_c: cover property (is_sub && sub_full[7:0] == 8'h00);
    cov_xor_zero_c: cover property (is_xor && xor_res == 8'h00);
    cov_tick_carry_c: cover property (watchdog_tick_in && !sleep_out && prescale_out == 8'hff);

endmodule : lit_ops_core

`default_nettype wire

// *** dv/test_literal_alu_and_powerdown_ops.sv ***
// Self-checking bench for the literal and power-down ops
`timescale 1ns/10ps
`default_nettype none
module test_literal_alu_and_powerdown_ops;
    import lit_ops_pkg::*;
    logic        clk_sys_in, rst_n_in, exec_valid_in, wake_in, watchdog_tick_in;
    logic [13:0] insn_in;
    logic [7:0]  acc_out, watchdog_out, prescale_out, acc_m;
    status_t     status_out, st_m;
    logic        osc_run_out, sleep_out;
    int          bad_count, tests_run;
    lit_ops_core i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .exec_valid_in(exec_valid_in), .insn_in(insn_in), .wake_in(wake_in),
        .watchdog_tick_in(watchdog_tick_in), .acc_out(acc_out), .watchdog_out(watchdog_out),
        .prescale_out(prescale_out), .status_out(status_out), .osc_run_out(osc_run_out),
        .sleep_out(sleep_out));
    // Clock at 200 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // Compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Execute one word for one cycle, then let the update land
    task automatic run(input logic [13:0] w);
        @(posedge clk_sys_in);
        exec_valid_in <= 1'b1;
        insn_in       <= w;
        @(posedge clk_sys_in);
        exec_valid_in <= 1'b0;
        #1;
    endtask : run
    // Outputs just after reset release
    task automatic t_reset;
        @(posedge clk_sys_in);
        #1;
        chk(acc_out, ACC_RST);
        chk(watchdog_out, WD_CLEAR);
        chk(prescale_out, PS_CLEAR);
        chk({3'h0, status_out}, {3'h0, STATUS_RST});
        chk({6'h0, sleep_out, osc_run_out}, 8'h01);
        $display("reset test done");
    endtask : t_reset
    // Literal minus accumulator with flag model
    task automatic t_sub(input logic [13:0] w);
        st_m.carry       = (w[7:0] >= acc_m);
        st_m.digit_carry = (w[3:0] >= acc_m[3:0]);
        acc_m            = w[7:0] - acc_m;
        st_m.zero        = (acc_m == 8'h00);
        run(w);
        chk(acc_out, acc_m);
        chk({3'h0, status_out}, {3'h0, st_m});
        $display("sub test %h done", w);
    endtask : t_sub
    // Xor literal, only zero may move
    task automatic t_xor(input logic [7:0] k);
        acc_m     = acc_m ^ k;
        st_m.zero = (acc_m == 8'h00);
        run({XOR_OPC, k});
        chk(acc_out, acc_m);
        chk({3'h0, status_out}, {3'h0, st_m});
        $display("xor test %h done", k);
    endtask : t_xor
    // Power-down after 257 ticks, ignored word, then wake
    task automatic t_sleep;
        @(posedge clk_sys_in);
        watchdog_tick_in <= 1'b1;
        repeat (257) @(posedge clk_sys_in);
        watchdog_tick_in <= 1'b0;
        #1;
        chk(watchdog_out, 8'h01);
        chk(prescale_out, 8'h01);
        st_m.powerdown_n = 1'b0;
        run(PWRDN_WORD);
        chk({6'h0, sleep_out, osc_run_out}, 8'h02);
        chk(watchdog_out, WD_CLEAR);
        chk(prescale_out, PS_CLEAR);
        chk({3'h0, status_out}, {3'h0, st_m});
        run({XOR_OPC, 8'hff});
        chk(acc_out, acc_m);
        @(posedge clk_sys_in);
        wake_in <= 1'b1;
        @(posedge clk_sys_in);
        wake_in <= 1'b0;
        #1;
        chk({6'h0, sleep_out, osc_run_out}, 8'h01);
        chk({3'h0, status_out}, {3'h0, st_m});
        $display("power-down test done");
    endtask : t_sleep
    // Verdict and end of run
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        {rst_n_in, exec_valid_in, wake_in, watchdog_tick_in, insn_in} = '0;
        {bad_count, tests_run} = '0;
        acc_m = ACC_RST;
        st_m  = STATUS_RST;
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_xor(8'hb5);
        t_xor(8'haf);
        t_xor(8'h1b);
        t_sub(14'h3c02);
        t_sub(14'h3d01);
        t_xor(8'h03);
        t_sub(14'h3c02);
        t_xor(8'hff);
        t_sleep();
        end_of_test();
    end
    // Hang guard, far beyond the expected run
    initial begin
        #5000;
        bad_count++;
        end_of_test();
    end
endmodule : test_literal_alu_and_powerdown_ops
`default_nettype wire
